// *** hw/msint_pkg.sv ***
package msint_pkg;

  // Register byte addresses on the Avalon-MM slave.
  localparam logic [5:0] ADDR_CORE_STATUS   = 6'h00;
  localparam logic [5:0] ADDR_IRQ_ENABLE    = 6'h04;
  localparam logic [5:0] ADDR_DROP_STATUS   = 6'h08;
  localparam logic [5:0] ADDR_WARN_LEVEL    = 6'h0C;
  localparam logic [5:0] ADDR_PN_LOW        = 6'h10;
  localparam logic [5:0] ADDR_PN_HIGH       = 6'h14;
  localparam logic [5:0] ADDR_PN_FLOW       = 6'h18;
  localparam logic [5:0] ADDR_PN_UPDATE     = 6'h1C;
  localparam logic [5:0] ADDR_OVERRUN       = 6'h20;
  localparam logic [5:0] ADDR_EG_UNTAGGED   = 6'h24;

  // Crypto-core status bit positions.
  localparam int BIT_INPUT_ERR    = 0;
  localparam int BIT_OUTPUT_ERR   = 1;
  localparam int BIT_PROC_ERR     = 2;
  localparam int BIT_CONTEXT_ERR  = 3;
  localparam int BIT_THRESHOLD    = 4;
  localparam int BIT_ROLLOVER     = 5;
  localparam int BIT_FATAL_ERR    = 14;

  // Drop status bit positions: ingress in 3:0, egress in 6:4.
  localparam int BIT_IG_CLASS   = 0;
  localparam int BIT_IG_CONSIST = 1;
  localparam int BIT_IG_POST    = 2;
  localparam int BIT_IG_MTU     = 3;
  localparam int BIT_EG_CLASS   = 4;
  localparam int BIT_EG_POST    = 5;
  localparam int BIT_EG_MTU     = 6;

  // Enable register: bit 0 core on ingress, bit 1 core on egress,
  // bits 8:2 map onto the drop status bits 6:0.
  localparam int EN_CORE_IG  = 0;
  localparam int EN_CORE_EG  = 1;
  localparam int EN_DROP_LSB = 2;

  localparam logic [31:0] CORE_STATUS_MASK = 32'h0000_403F;
  localparam logic [31:0] DROP_STATUS_MASK = 32'h0000_007F;
  localparam logic [31:0] IRQ_ENABLE_MASK  = 32'h0000_01FF;
  localparam logic [31:0] WARN_LEVEL_RESET = 32'hF000_0000;
  localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;
  localparam logic [31:0] READ_ERR_WORD    = 32'hDEAD_BEEF;

  localparam int N_IRQ = 9;

endpackage

// *** hw/msint_top.sv ***
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none

module msint_top #(
  parameter int FLOW_W = 8,
  parameter int CNT_W  = 40,
  parameter int OCT_W  = 80
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [5:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic [31:0]            avs_readdata_o,
  output logic                   avs_waitrequest_o,
  input  wire logic              ig_core_input_err_i,
  input  wire logic              ig_core_output_err_i,
  input  wire logic              ig_core_proc_err_i,
  input  wire logic              ig_core_context_err_i,
  input  wire logic              ig_core_fatal_err_i,
  input  wire logic              eg_core_input_err_i,
  input  wire logic              eg_core_output_err_i,
  input  wire logic              eg_core_proc_err_i,
  input  wire logic              eg_core_context_err_i,
  input  wire logic              eg_core_fatal_err_i,
  input  wire logic              eg_pn_valid_i,
  input  wire logic              eg_pn_xpn_i,
  input  wire logic [63:0]       eg_pn_i,
  input  wire logic              ig_class_drop_i,
  input  wire logic              ig_consist_drop_i,
  input  wire logic              ig_post_drop_i,
  input  wire logic              ig_mtu_drop_i,
  input  wire logic              eg_class_drop_i,
  input  wire logic              eg_post_drop_i,
  input  wire logic              eg_mtu_drop_i,
  input  wire logic              eg_untagged_i,
  input  wire logic              ig_sa_octet_valid_i,
  input  wire logic [15:0]       ig_sa_octets_i,
  input  wire logic              eg_sa_pkt_i,
  output logic [OCT_W-1:0]       ig_sa_octet_count_o,
  output logic [CNT_W-1:0]       eg_sa_pkt_count_o,
  output logic                   ctx_req_o,
  output logic [FLOW_W-1:0]      ctx_flow_o,
  input  wire logic              ctx_ack_i,
  input  wire logic [63:0]       ctx_next_pn_i,
  input  wire logic [63:0]       ctx_lowest_pn_i,
  output logic                   ctx_we_o,
  output logic [63:0]            ctx_next_pn_o,
  output logic [63:0]            ctx_lowest_pn_o,
  output logic [msint_pkg::N_IRQ-1:0] irq_o
);

  // ---------------------------------------------------------------------
  // Update sequencer states
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    UPD_IDLE  = 4'b0001,
    UPD_FETCH = 4'b0010,
    UPD_WRITE = 4'b0100,
    UPD_DONE  = 4'b1000
  } msint_upd_t;

  msint_upd_t   upd_reg;
  msint_upd_t   upd_next;

  logic [31:0]  ig_core_reg;
  logic [31:0]  eg_core_reg;
  logic [31:0]  drop_reg;
  logic [31:0]  enable_reg;
  logic [31:0]  warn_reg;
  logic [31:0]  pn_low_reg;
  logic [31:0]  pn_high_reg;
  logic [FLOW_W-1:0] flow_reg;
  logic         update_reg;
  logic [CNT_W-1:0] untag_reg;
  logic         ack_reg;
  logic [31:0]  rdata_reg;

  // ---------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------
  // The slave answers one cycle after the request: waitrequest is high on
  // the first cycle and low on the second, so each access takes two edges.
  wire bus_req  = (avs_read_i | avs_write_i) & ~ack_reg;
  wire wr_fire  = avs_write_i & ack_reg;
  wire [31:0] be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                         {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire [31:0] wdata = avs_writedata_i & be_mask;

  function automatic logic wr_hit(input logic [5:0] a);
    wr_hit = wr_fire & (avs_address_i == a);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~be_mask) | wdata;
  endfunction

  // ---------------------------------------------------------------------
  // Event sources
  // ---------------------------------------------------------------------
  wire [31:0] pn32_ext = eg_pn_i[31:0];
  wire eg_thresh = eg_pn_valid_i & (pn32_ext > warn_reg);
  wire eg_roll   = eg_pn_valid_i & (eg_pn_xpn_i ?
                   (eg_pn_i == {64{1'b1}}) :
                   (pn32_ext == {32{1'b1}}));

  function automatic logic [31:0] core_ev(input logic in_e, input logic out_e,
      input logic proc_e, input logic ctx_e, input logic fat_e,
      input logic thr_e, input logic rol_e);
    logic [31:0] v;
    v = msint_pkg::ZERO_WORD;
    v[msint_pkg::BIT_INPUT_ERR]   = in_e;
    v[msint_pkg::BIT_OUTPUT_ERR]  = out_e;
    v[msint_pkg::BIT_FATAL_ERR]   = fat_e;
    v[msint_pkg::BIT_PROC_ERR]    = proc_e;
    v[msint_pkg::BIT_CONTEXT_ERR] = ctx_e;
    v[msint_pkg::BIT_THRESHOLD]   = thr_e;
    v[msint_pkg::BIT_ROLLOVER]    = rol_e;
    core_ev = v;
  endfunction

  wire [31:0] ig_core_set = core_ev(ig_core_input_err_i, ig_core_output_err_i,
      ig_core_proc_err_i, ig_core_context_err_i, ig_core_fatal_err_i,
      1'b0, 1'b0);
  wire [31:0] eg_core_set = core_ev(eg_core_input_err_i, eg_core_output_err_i,
      eg_core_proc_err_i, eg_core_context_err_i, eg_core_fatal_err_i,
      eg_thresh, eg_roll);

  wire [31:0] drop_set = {25'h0000000, eg_mtu_drop_i, eg_post_drop_i,
      eg_class_drop_i, ig_mtu_drop_i, ig_post_drop_i, ig_consist_drop_i,
      ig_class_drop_i};

  // Set wins over a write-one-to-clear in the same cycle.
  function automatic logic [31:0] w1c(input logic [31:0] old,
      input logic [31:0] set, input logic hit, input logic [31:0] mask);
    w1c = ((old & ~(hit ? wdata : msint_pkg::ZERO_WORD)) | set) & mask;
  endfunction

  // Egress core status has an address of its own, so that both banks keep
  // the same bit numbers and one clear mask serves both.
  wire [31:0] ig_core_next = w1c(ig_core_reg, ig_core_set,
      wr_hit(msint_pkg::ADDR_CORE_STATUS), msint_pkg::CORE_STATUS_MASK);
  wire [31:0] eg_core_next = w1c(eg_core_reg, eg_core_set,
      wr_hit(msint_pkg::ADDR_OVERRUN), msint_pkg::CORE_STATUS_MASK);
  wire [31:0] drop_next = w1c(drop_reg, drop_set,
      wr_hit(msint_pkg::ADDR_DROP_STATUS), msint_pkg::DROP_STATUS_MASK);

  // ---------------------------------------------------------------------
  // Packet-number update sequencer
  // ---------------------------------------------------------------------
  wire [63:0] req_pn   = {pn_high_reg, pn_low_reg};
  wire        pn_grows = req_pn > ctx_next_pn_i;
  wire [63:0] pn_delta = req_pn - ctx_next_pn_i;
  wire [63:0] low_next = ctx_lowest_pn_i + pn_delta;

  always_comb
  begin
    upd_next = upd_reg;
    unique case (upd_reg)
      UPD_IDLE:  if (update_reg) upd_next = UPD_FETCH;
      UPD_FETCH: if (ctx_ack_i) upd_next = pn_grows ? UPD_WRITE : UPD_DONE;
      UPD_WRITE: upd_next = UPD_DONE;
      UPD_DONE:  upd_next = UPD_IDLE;
    endcase
  end

  wire upd_start = wr_hit(msint_pkg::ADDR_PN_UPDATE) & wdata[0];
  wire update_next = (upd_reg == UPD_DONE) ? 1'b0 :
                     (upd_start ? 1'b1 : update_reg);

  // ---------------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------------
  wire [OCT_W-1:0] oct_add = {{(OCT_W-16){1'b0}}, ig_sa_octets_i};

  // ---------------------------------------------------------------------
  // Interrupt outputs and read mux
  // ---------------------------------------------------------------------
  wire [31:0] irq_src_en = enable_reg;
  wire [msint_pkg::N_IRQ-1:0] irq_next = {
      |(drop_reg[6:4] & irq_src_en[8:6]) ? 1'b0 : 1'b0,
      8'h00} | {
      drop_reg[msint_pkg::BIT_EG_MTU]     & enable_reg[8],
      drop_reg[msint_pkg::BIT_EG_POST]    & enable_reg[7],
      drop_reg[msint_pkg::BIT_EG_CLASS]   & enable_reg[6],
      |eg_core_reg                        & enable_reg[msint_pkg::EN_CORE_EG],
      drop_reg[msint_pkg::BIT_IG_MTU]     & enable_reg[5],
      drop_reg[msint_pkg::BIT_IG_POST]    & enable_reg[4],
      drop_reg[msint_pkg::BIT_IG_CONSIST] & enable_reg[3],
      drop_reg[msint_pkg::BIT_IG_CLASS]   & enable_reg[msint_pkg::EN_DROP_LSB],
      |ig_core_reg                        & enable_reg[msint_pkg::EN_CORE_IG]
  };

  wire [5:0] ra = avs_address_i;
  wire [31:0] rd_mux =
      (ra == msint_pkg::ADDR_CORE_STATUS) ? ig_core_reg :
      (ra == msint_pkg::ADDR_IRQ_ENABLE)  ? enable_reg :
      (ra == msint_pkg::ADDR_DROP_STATUS) ? drop_reg :
      (ra == msint_pkg::ADDR_WARN_LEVEL)  ? warn_reg :
      (ra == msint_pkg::ADDR_PN_LOW)      ? pn_low_reg :
      (ra == msint_pkg::ADDR_PN_HIGH)     ? pn_high_reg :
      (ra == msint_pkg::ADDR_PN_FLOW)     ?
          {{(32-FLOW_W){1'b0}}, flow_reg} :
      (ra == msint_pkg::ADDR_PN_UPDATE)   ? {31'h00000000, update_reg} :
      (ra == msint_pkg::ADDR_OVERRUN)     ? eg_core_reg :
      (ra == msint_pkg::ADDR_EG_UNTAGGED) ? untag_reg[31:0] :
      msint_pkg::ZERO_WORD;

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_reg     <= 1'b0;
      rdata_reg   <= msint_pkg::ZERO_WORD;
      ig_core_reg <= msint_pkg::ZERO_WORD;
      eg_core_reg <= msint_pkg::ZERO_WORD;
      drop_reg    <= msint_pkg::ZERO_WORD;
      enable_reg  <= msint_pkg::ZERO_WORD;
      warn_reg    <= msint_pkg::WARN_LEVEL_RESET;
      pn_low_reg  <= msint_pkg::ZERO_WORD;
      pn_high_reg <= msint_pkg::ZERO_WORD;
      flow_reg    <= '0;
      update_reg  <= 1'b0;
      upd_reg     <= UPD_IDLE;
      untag_reg   <= '0;
      irq_o       <= '0;
    end
    else
    begin
      ack_reg     <= bus_req;
      rdata_reg   <= rd_mux;
      ig_core_reg <= ig_core_next;
      eg_core_reg <= eg_core_next;
      drop_reg    <= drop_next;
      if (wr_hit(msint_pkg::ADDR_IRQ_ENABLE))
        enable_reg <= merge(enable_reg) & msint_pkg::IRQ_ENABLE_MASK;
      if (wr_hit(msint_pkg::ADDR_WARN_LEVEL))
        warn_reg <= merge(warn_reg);
      if (wr_hit(msint_pkg::ADDR_PN_LOW))
        pn_low_reg <= merge(pn_low_reg);
      if (wr_hit(msint_pkg::ADDR_PN_HIGH))
        pn_high_reg <= merge(pn_high_reg);
      if (wr_hit(msint_pkg::ADDR_PN_FLOW))
        flow_reg <= FLOW_W'(merge({{(32-FLOW_W){1'b0}}, flow_reg}));
      update_reg  <= update_next;
      upd_reg     <= upd_next;
      if (eg_untagged_i)
        untag_reg <= untag_reg + 1'b1;
      irq_o       <= irq_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ig_sa_octet_count_o <= '0;
      eg_sa_pkt_count_o   <= '0;
      ctx_req_o           <= 1'b0;
      ctx_flow_o          <= '0;
      ctx_we_o            <= 1'b0;
      ctx_next_pn_o       <= '0;
      ctx_lowest_pn_o     <= '0;
    end
    else
    begin
      if (ig_sa_octet_valid_i)
        ig_sa_octet_count_o <= ig_sa_octet_count_o + oct_add;
      if (eg_sa_pkt_i)
        eg_sa_pkt_count_o <= eg_sa_pkt_count_o + 1'b1;
      ctx_req_o  <= (upd_next == UPD_FETCH);
      ctx_flow_o <= flow_reg;
      ctx_we_o   <= (upd_reg == UPD_FETCH) & ctx_ack_i & pn_grows;
      if ((upd_reg == UPD_FETCH) & ctx_ack_i)
      begin
        ctx_next_pn_o   <= req_pn;
        ctx_lowest_pn_o <= low_next;
      end
    end
  end

  assign avs_readdata_o    = rdata_reg;
  assign avs_waitrequest_o = ~ack_reg;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  a_w1c_set_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ig_core_input_err_i |=> ig_core_reg[msint_pkg::BIT_INPUT_ERR])
    else $error("input error not latched");
  a_fatal_latch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    eg_core_fatal_err_i |=> eg_core_reg[msint_pkg::BIT_FATAL_ERR])
    else $error("fatal error not latched");
  a_w1c_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_hit(msint_pkg::ADDR_CORE_STATUS) && wdata[msint_pkg::BIT_PROC_ERR]
     && !ig_core_proc_err_i) |=> !ig_core_reg[msint_pkg::BIT_PROC_ERR])
    else $error("write one did not clear");
  a_thresh_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    eg_thresh |=> eg_core_reg[msint_pkg::BIT_THRESHOLD])
    else $error("threshold not flagged");
  a_roll_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    eg_roll |=> eg_core_reg[msint_pkg::BIT_ROLLOVER])
    else $error("rollover not flagged");
  a_mtu_irq: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ig_mtu_drop_i && enable_reg[5]) |=> ##1 irq_o[4])
    else $error("mtu drop irq missing");
  a_irq_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!enable_reg[msint_pkg::EN_CORE_IG]) |=> !irq_o[0])
    else $error("masked irq asserted");
  a_no_shrink: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctx_we_o |-> (ctx_next_pn_o > $past(ctx_next_pn_i)))
    else $error("context number did not grow");
  a_upd_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (upd_reg == UPD_DONE) |=> !update_reg)
    else $error("update enable not cleared");
  a_class_drop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ig_class_drop_i |=> drop_reg[msint_pkg::BIT_IG_CLASS])
    else $error("class drop not latched");
  a_consist_drop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ig_consist_drop_i |=> drop_reg[msint_pkg::BIT_IG_CONSIST])
    else $error("consistency drop not latched");
  a_post_drop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    eg_post_drop_i |=> drop_reg[msint_pkg::BIT_EG_POST])
    else $error("post drop not latched");
  a_out_latch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ig_core_output_err_i |=> ig_core_reg[msint_pkg::BIT_OUTPUT_ERR])
    else $error("output error not latched");
  a_proc_latch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ig_core_proc_err_i |=> ig_core_reg[msint_pkg::BIT_PROC_ERR])
    else $error("processing error not latched");
  a_ctx_latch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    eg_core_context_err_i |=> eg_core_reg[msint_pkg::BIT_CONTEXT_ERR])
    else $error("context error not latched");
  a_upd_fetch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (upd_reg == UPD_IDLE && update_reg) |=> ctx_req_o)
    else $error("update did not fetch context");
  a_we_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctx_we_o |=> !ctx_we_o)
    else $error("context write longer than one cycle");
  a_octet_add: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ig_sa_octet_valid_i |=> (ig_sa_octet_count_o ==
      $past(ig_sa_octet_count_o) + $past(oct_add)))
    else $error("octet counter did not add");

endmodule

`default_nettype wire

// *** verif/msint_ctx_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module msint_ctx_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        slow_i,
  input  wire logic        req_i,
  input  wire logic [7:0]  flow_i,
  input  wire logic        we_i,
  input  wire logic [63:0] next_i,
  input  wire logic [63:0] low_i,
  output logic             ack_o,
  output logic [63:0]      next_o,
  output logic [63:0]      low_o
);
  // Four records; each starts at next 64'h64 and lowest 64'h44.
  logic [63:0] nxt_reg [4];
  logic [63:0] low_reg [4];
  logic [2:0]  dly_reg;
  logic        served_reg;

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      nxt_reg <= '{4{64'h64}};
      low_reg <= '{4{64'h44}};
      dly_reg <= 3'h0;
      served_reg <= 1'b0;
      ack_o <= 1'b0;
      next_o <= 64'h0;
      low_o <= 64'h0;
    end
    else
    begin
      // Data toggles outside the answer, so a late sample is caught.
      ack_o <= 1'b0;
      next_o <= ~next_o;
      low_o <= ~low_o;
      if (!req_i)
      begin
        served_reg <= 1'b0;
        dly_reg <= 3'h0;
      end
      else if (!served_reg && dly_reg >= (slow_i ? 3'h5 : 3'h0))
      begin
        ack_o <= 1'b1;
        served_reg <= 1'b1;
        next_o <= nxt_reg[flow_i[1:0]];
        low_o <= low_reg[flow_i[1:0]];
      end
      else if (!served_reg)
        dly_reg <= dly_reg + 3'h1;
      if (we_i)
      begin
        nxt_reg[flow_i[1:0]] <= next_i;
        low_reg[flow_i[1:0]] <= low_i;
      end
    end
  end
endmodule

`default_nettype wire

// *** verif/tb_macsec_interrupts_and_pn_update.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) \
  begin \
    checked++; \
    if ((gt) !== (ex)) \
    begin \
      bad_count++; \
      $display("BAD %s exp %h got %h", nm, ex, gt); \
    end \
  end

module tb_macsec_interrupts_and_pn_update;
  localparam logic [5:0] EG_CORE = 6'h20;
  logic clk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [5:0] avs_address_i = 6'h00;
  logic [31:0] avs_writedata_i = 32'h0, rdata;
  logic [4:0] ig_err = 5'h0, eg_err = 5'h0;
  logic [6:0] drop = 7'h0;
  logic eg_pn_valid_i = 1'b0, eg_pn_xpn_i = 1'b0, eg_untagged_i = 1'b0;
  logic ig_sa_octet_valid_i = 1'b0, eg_sa_pkt_i = 1'b0, slow = 1'b0;
  logic [63:0] eg_pn_i = 64'h0;
  logic [15:0] ig_sa_octets_i = 16'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, ctx_req_o, ctx_ack_i, ctx_we_o;
  logic [8:0] irq_o;
  logic [79:0] ig_sa_octet_count_o;
  logic [39:0] eg_sa_pkt_count_o;
  logic [7:0] ctx_flow_o;
  logic [63:0] ctx_next_pn_i, ctx_lowest_pn_i, ctx_next_pn_o, ctx_lowest_pn_o;
  logic [32:0] rq [$];
  logic [32:0] rv;
  logic [127:0] wq [$];
  logic [127:0] wv;
  int bad_count = 0, checked = 0, we_seen = 0;

  always #5 clk_i = ~clk_i;

  msint_top dut (
    .clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i(4'hF), .avs_readdata_o,
    .avs_waitrequest_o,
    .ig_core_input_err_i(ig_err[0]), .ig_core_output_err_i(ig_err[1]),
    .ig_core_proc_err_i(ig_err[2]), .ig_core_context_err_i(ig_err[3]),
    .ig_core_fatal_err_i(ig_err[4]),
    .eg_core_input_err_i(eg_err[0]), .eg_core_output_err_i(eg_err[1]),
    .eg_core_proc_err_i(eg_err[2]), .eg_core_context_err_i(eg_err[3]),
    .eg_core_fatal_err_i(eg_err[4]), .eg_pn_valid_i, .eg_pn_xpn_i, .eg_pn_i,
    .ig_class_drop_i(drop[0]), .ig_consist_drop_i(drop[1]),
    .ig_post_drop_i(drop[2]), .ig_mtu_drop_i(drop[3]),
    .eg_class_drop_i(drop[4]), .eg_post_drop_i(drop[5]),
    .eg_mtu_drop_i(drop[6]), .eg_untagged_i, .ig_sa_octet_valid_i,
    .ig_sa_octets_i, .eg_sa_pkt_i, .ig_sa_octet_count_o, .eg_sa_pkt_count_o,
    .ctx_req_o, .ctx_flow_o, .ctx_ack_i, .ctx_next_pn_i, .ctx_lowest_pn_i,
    .ctx_we_o, .ctx_next_pn_o, .ctx_lowest_pn_o, .irq_o);

  msint_ctx_model ctx (
    .clk_i, .rst_n_i, .slow_i(slow), .req_i(ctx_req_o), .flow_i(ctx_flow_o),
    .we_i(ctx_we_o), .next_i(ctx_next_pn_o), .low_i(ctx_lowest_pn_o),
    .ack_o(ctx_ack_i), .next_o(ctx_next_pn_i), .low_o(ctx_lowest_pn_i));

  // ----------------------------------------------------------------------
  // Monitor.
  // ----------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (avs_read_i && avs_waitrequest_o === 1'b0 && rq.size() > 0)
    begin
      rv = rq.pop_front();
      if (rv[32])
        `CHK("readdata", rv[31:0], avs_readdata_o)
    end
    if (ctx_we_o === 1'b1)
    begin
      we_seen++;
      if (wq.size() == 0)
        `CHK("ctx_we", 1'b0, ctx_we_o)
      else
      begin
        wv = wq.pop_front();
        `CHK("ctx_next_pn", wv[127:64], ctx_next_pn_o)
        `CHK("ctx_lowest_pn", wv[63:0], ctx_lowest_pn_o)
      end
    end
  end

  task automatic print_verdict();
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic hang();
    bad_count++;
    print_verdict();
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  // The request holds until a rising edge samples waitrequest low; the
  // read data is taken at that edge and only then is the request dropped.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_read_i <= ~w;
    avs_write_i <= w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (n >= 20)
      hang();
    rdata = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    rq.push_back({1'b1, e});
    bus(1'b0, a, 32'h0);
  endtask

  task automatic pn_ev(input logic x, input logic [63:0] p);
    @(posedge clk_i);
    eg_pn_valid_i <= 1'b1;
    eg_pn_xpn_i <= x;
    eg_pn_i <= p;
    @(posedge clk_i);
    eg_pn_valid_i <= 1'b0;
    settle();
  endtask

  task automatic pn_upd(input logic [7:0] f, input logic [63:0] q,
                        input logic [63:0] sn, input logic [63:0] sl);
    int n;
    n = 0;
    if (q > sn)
      wq.push_back({q, sl + (q - sn)});
    bus(1'b1, msint_pkg::ADDR_PN_LOW, q[31:0]);
    bus(1'b1, msint_pkg::ADDR_PN_HIGH, q[63:32]);
    bus(1'b1, msint_pkg::ADDR_PN_FLOW, {24'h0, f});
    bus(1'b1, msint_pkg::ADDR_PN_UPDATE, 32'h1);
    do
    begin
      rq.push_back(33'h0);
      bus(1'b0, msint_pkg::ADDR_PN_UPDATE, 32'h0);
      n++;
    end
    while (rdata[0] !== 1'b0 && n < 30);
    if (n >= 30)
      hang();
    rd(msint_pkg::ADDR_PN_UPDATE, 32'h0);
  endtask

  // ----------------------------------------------------------------------
  // Stimulus.
  // ----------------------------------------------------------------------
  initial
  begin
    logic [31:0] lvl, st;
    logic [8:0] ib;
    logic [79:0] osum;
    logic [63:0] q1;
    logic [63:0] tp [5];
    logic [31:0] te [5];
    logic tx [5];
    lvl = $urandom(29);
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    settle();
    `CHK("irq_reset", 9'h000, irq_o)
    rd(msint_pkg::ADDR_WARN_LEVEL, msint_pkg::WARN_LEVEL_RESET);
    bus(1'b1, msint_pkg::ADDR_IRQ_ENABLE, msint_pkg::IRQ_ENABLE_MASK);
    for (int c = 0; c < 2; c++)
      for (int k = 0; k < 5; k++)
      begin
        @(posedge clk_i);
        ig_err <= (c == 0) ? 5'h01 << k : 5'h00;
        eg_err <= (c == 1) ? 5'h01 << k : 5'h00;
        @(posedge clk_i);
        ig_err <= 5'h00;
        eg_err <= 5'h00;
        settle();
        st = (k == 4) ? 32'h0000_4000 : 32'h1 << k;
        `CHK("irq_core", 9'h001 << (5 * c), irq_o)
        rd(c ? EG_CORE : msint_pkg::ADDR_CORE_STATUS, st);
        bus(1'b1, c ? EG_CORE : msint_pkg::ADDR_CORE_STATUS, st);
        rd(c ? EG_CORE : msint_pkg::ADDR_CORE_STATUS, 32'h0);
        settle();
        `CHK("irq_core_clear", 9'h000, irq_o)
      end
    for (int k = 0; k < 7; k++)
    begin
      @(posedge clk_i);
      drop <= 7'h01 << k;
      @(posedge clk_i);
      drop <= 7'h00;
      settle();
      ib = (k < 4) ? 9'h002 << k : 9'h040 << (k - 4);
      `CHK("irq_drop", ib, irq_o)
      rd(msint_pkg::ADDR_DROP_STATUS, 32'h1 << k);
      bus(1'b1, msint_pkg::ADDR_IRQ_ENABLE, 32'h1FF & ~(32'h4 << k));
      settle();
      `CHK("irq_masked", 9'h000, irq_o)
      bus(1'b1, msint_pkg::ADDR_IRQ_ENABLE, msint_pkg::IRQ_ENABLE_MASK);
      settle();
      `CHK("irq_unmasked", ib, irq_o)
      bus(1'b1, msint_pkg::ADDR_DROP_STATUS, 32'h1 << k);
      settle();
      `CHK("irq_drop_clear", 9'h000, irq_o)
    end
    lvl = 32'h8000_0000 | ($urandom & 32'h0000_FFFF);
    bus(1'b1, msint_pkg::ADDR_WARN_LEVEL, lvl);
    rd(msint_pkg::ADDR_WARN_LEVEL, lvl);
    tp = '{{32'h0, lvl}, {32'h0, lvl + 32'h1}, 64'h0000_0000_FFFF_FFFF,
           64'h0000_0000_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_FFFF};
    tx = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    te = '{32'h00, 32'h10, 32'h10, 32'h30, 32'h30};
    for (int i = 0; i < 5; i++)
    begin
      pn_ev(tx[i], tp[i]);
      rd(EG_CORE, te[i]);
      bus(1'b1, msint_pkg::ADDR_IRQ_ENABLE, 32'h1FD);
      bus(1'b1, EG_CORE, te[i]);
      settle();
      `CHK("irq_eg_clear", 9'h000, irq_o)
      bus(1'b1, msint_pkg::ADDR_IRQ_ENABLE, msint_pkg::IRQ_ENABLE_MASK);
    end
    osum = 80'h0;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_i);
      st = $urandom;
      osum += st[15:0];
      ig_sa_octets_i <= st[15:0];
      ig_sa_octet_valid_i <= 1'b1;
      eg_sa_pkt_i <= 1'b1;
      eg_untagged_i <= 1'b1;
    end
    @(posedge clk_i);
    ig_sa_octet_valid_i <= 1'b0;
    eg_sa_pkt_i <= 1'b0;
    eg_untagged_i <= 1'b0;
    settle();
    `CHK("ig_octets", osum, ig_sa_octet_count_o)
    `CHK("eg_pkts", 40'h3, eg_sa_pkt_count_o)
    rd(msint_pkg::ADDR_EG_UNTAGGED, 32'h3);
    bus(1'b1, 6'h28, $urandom);
    rd(6'h28, 32'h0);
    q1 = {32'h0 | ($urandom & 32'h3), 32'h100 | ($urandom & 32'hFFFF)};
    pn_upd(8'h02, q1, 64'h64, 64'h44);
    pn_upd(8'h02, q1, q1, 64'h0);
    pn_upd(8'h02, q1 - 64'h1, q1, 64'h0);
    slow <= 1'b1;
    pn_upd(8'h01, 64'h65, 64'h64, 64'h44);
    `CHK("ctx_we_count", 2, we_seen)
    print_verdict();
  end
endmodule

`default_nettype wire
